//--- dv/fdo_debug_override_ctrl_tb.sv
// self-checking bench for the debug loop override control block
`default_nettype none

module fdo_debug_override_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [fdo_pkg::ADDR_W-1:0] reg_addr = 12'h000;
  logic [fdo_pkg::DATA_W-1:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [fdo_pkg::DATA_W-1:0] reg_rdata;
  logic [fdo_pkg::CODE_W-1:0] kp = 10'h000;
  logic [fdo_pkg::CODE_W-1:0] ki = 10'h000;
  logic meas_busy = 1'b0;
  fdo_pkg::fdo_vref_t vref;
  fdo_pkg::fdo_meas_sel_t meas_sel;
  logic meas_start;
  logic shadow_commit;
  int fails = 0;
  int num_checks = 0;
  logic [31:0] rv;
  logic [9:0] codes [11] = '{10'h000, 10'h001, 10'h0fa, 10'h1f4, 10'h1f5, 10'h1ff,
                             10'h200, 10'h201, 10'h3e8, 10'h3e9, 10'h3ff};

  always #2 core_clk = ~core_clk;

  fdo_debug_override_ctrl fdo_debug_override_ctrl_inst (
    .core_clk(core_clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .inner_loop_prop_gain(kp),
    .inner_loop_int_gain(ki),
    .meas_busy(meas_busy),
    .vref(vref),
    .meas_start(meas_start),
    .meas_sel(meas_sel),
    .shadow_commit(shadow_commit)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t pulse got %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // outputs of the taking edge are settled when the task returns
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  function automatic logic [31:0] word(input logic b, input logic [9:0] d, input logic [9:0] q,
                                       input logic t, input logic [3:0] s, input logic c);
    return {5'h00, b, d, q, t, s, c};
  endfunction : word

  // invalid codes give zero
  function automatic logic signed [10:0] dec(input logic [9:0] c);
    if (c <= 10'h1f4) return {1'b0, c};
    if (c >= 10'h200 && c <= 10'h3e8) return 11'sh000 - {1'b0, c - 10'h200};
    return 11'sh000;
  endfunction : dec

  function automatic logic [31:0] expv(input logic b, input logic [9:0] d, input logic [9:0] q);
    fdo_pkg::fdo_vref_t e;
    e.inner_loop_bypass = b;
    e.vd_ref = b ? dec(d) : 11'sh000;
    e.vq_ref = b ? dec(q) : 11'sh000;
    return {9'h000, e};
  endfunction : expv

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk32({9'h000, vref}, 32'h0000_0000);
    chk32({28'h000_0000, meas_sel}, 32'h0000_0000);
    rd(12'h0ee, rv);
    chk32(rv, 32'h0000_0000);
    rd(12'h0f0, rv);
    chk32(rv, 32'h0000_0000);
    foreach (codes[i]) begin
      wr(12'h0ee, word(1'b1, codes[i], codes[10-i], 1'b0, 4'h0, 1'b0));
      chk32({9'h000, vref}, expv(1'b1, codes[i], codes[10-i]));
    end
    // last codes: d invalid, q valid, bypass set
    rd(12'h0f8, rv);
    chk32(rv, 32'h0000_0003);
    rd(12'h0ee, rv);
    chk32(rv, 32'h0000_0000);
    wr(12'h0ee, word(1'b0, 10'h0fa, 10'h201, 1'b0, 4'h0, 1'b0));
    chk32({9'h000, vref}, 32'h0000_0000);
    wr(12'h0ee, word(1'b0, 10'h1f8, 10'h3f0, 1'b0, 4'h0, 1'b0));
    rd(12'h0f8, rv);
    chk32(rv, 32'h0000_0006);
    wr(12'h0ee, 32'hf800_0000 | word(1'b1, 10'h064, 10'h2c8, 1'b0, 4'h0, 1'b0));
    chk32({9'h000, vref}, expv(1'b1, 10'h064, 10'h2c8));
    for (int i = 0; i < 4; i++) begin
      wr(12'h0ee, word(1'b0, 10'h000, 10'h000, 1'b1, 4'h1 << i, 1'b0));
      chk32({28'h000_0000, meas_sel}, {28'h000_0000, 4'h1 << i});
      chk1(meas_start, 1'b1);
      chk1(shadow_commit, 1'b0);
      @(posedge core_clk);
      #1;
      chk1(meas_start, 1'b0);
    end
    // trigger while the routine runs is dropped, new selection still taken
    @(posedge core_clk);
    meas_busy <= 1'b1;
    wr(12'h0ee, word(1'b0, 10'h000, 10'h000, 1'b1, 4'hf, 1'b0));
    chk1(meas_start, 1'b0);
    chk32({28'h000_0000, meas_sel}, 32'h0000_000f);
    rd(12'h0f8, rv);
    chk32(rv, 32'h0000_0008);
    @(posedge core_clk);
    meas_busy <= 1'b0;
    wr(12'h0ee, word(1'b0, 10'h000, 10'h000, 1'b0, 4'h0, 1'b1));
    chk1(shadow_commit, 1'b1);
    chk1(meas_start, 1'b0);
    @(posedge core_clk);
    #1;
    chk1(shadow_commit, 1'b0);
    @(posedge core_clk);
    kp <= 10'h3ff;
    ki <= 10'h155;
    rd(12'h0f0, rv);
    chk32(rv, {10'h3ff, 10'h155, 12'h000});
    @(posedge core_clk);
    #1;
    chk32(reg_rdata, 32'h0000_0000);
    rd(12'h100, rv);
    chk32(rv, 32'h0000_0000);
    wr(12'h100, word(1'b1, 10'h064, 10'h064, 1'b1, 4'h0, 1'b1));
    chk32({9'h000, vref}, 32'h0000_0000);
    chk1(meas_start, 1'b0);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    stop_test();
  end

endmodule : fdo_debug_override_ctrl_tb

`default_nettype wire

//--- src/fdo_debug_override_ctrl.sv
// debug loop override control register bank with gain readback
//
// Operation
// - debug control register at 0xEE, resets to zero, every field write-only
// - bypass bit 26 set disables current and speed loops
// - bypassed: direct-axis voltage reference comes from bits 25 to 16
// - d code 0 to 500 is +code/500, 512 to 1000 is -(code-512)/500
// - bypassed: quadrature-axis voltage reference comes from bits 15 to 6
// - q code decoded like d; valid codes 0-500 and 512-1000
// - writing one to bit 5 while meas_busy is low starts the parameter measurement routine
// - bit 4 selects winding resistance measurement
// - bit 3 selects winding inductance measurement
// - bit 2 selects back-EMF constant measurement
// - bit 1 selects mechanical parameter measurement
// - writing one to bit 0 commits measured parameters to shadow registers
// - gain readback register at 0xF0, resets to zero, shows gains in use
// - proportional gain bits 31-22, integral gain bits 21-12, rest reserved zero
`default_nettype none

module fdo_debug_override_ctrl (
  input wire logic core_clk, // 250 MHz core clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic [fdo_pkg::ADDR_W-1:0] reg_addr, // register address
  input wire logic [fdo_pkg::DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [fdo_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after read strobe
  input wire logic [fdo_pkg::CODE_W-1:0] inner_loop_prop_gain, // proportional gain in use
  input wire logic [fdo_pkg::CODE_W-1:0] inner_loop_int_gain, // integral gain in use
  input wire logic meas_busy, // measurement routine running
  output fdo_pkg::fdo_vref_t vref, // loop bypass and forced voltage references
  output logic meas_start, // one-cycle start of measurement routine
  output fdo_pkg::fdo_meas_sel_t meas_sel, // sub-measurements for the routine
  output logic shadow_commit // one-cycle commit to shadow registers
);

  ////////////////////////////////////////////////////////////////////////////////
  // decoding functions

  function automatic logic code_valid(input logic [fdo_pkg::CODE_W-1:0] code);
    code_valid = (code <= fdo_pkg::CODE_POS_MAX) ||
                 ((code >= fdo_pkg::CODE_NEG_BASE) && (code <= fdo_pkg::CODE_NEG_MAX));
  endfunction : code_valid

  // signed reference in units of 1/500; invalid codes force zero
  function automatic logic signed [fdo_pkg::REF_W-1:0] code_to_ref(
      input logic [fdo_pkg::CODE_W-1:0] code);
    logic [fdo_pkg::CODE_W-1:0] mag;
    mag = code - fdo_pkg::CODE_NEG_BASE;
    if (code <= fdo_pkg::CODE_POS_MAX) begin
      code_to_ref = {1'b0, code};
    end else if ((code >= fdo_pkg::CODE_NEG_BASE) && (code <= fdo_pkg::CODE_NEG_MAX)) begin
      code_to_ref = -$signed({1'b0, mag});
    end else begin
      code_to_ref = '0;
    end
  endfunction : code_to_ref

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  wire logic sel_ctrl;
  wire logic sel_gain;
  wire logic sel_status;
  wire logic wr_ctrl;
  wire fdo_pkg::fdo_ctrl_t wr_word;

  assign sel_ctrl = (reg_addr == fdo_pkg::DEBUG_LOOP_OVERRIDE_CTRL_OFS);
  assign sel_gain = (reg_addr == fdo_pkg::INNER_LOOP_GAIN_READBACK_OFS);
  assign sel_status = (reg_addr == fdo_pkg::OVERRIDE_STATUS_OFS);
  assign wr_ctrl = reg_wr && sel_ctrl;
  assign wr_word = fdo_pkg::fdo_ctrl_t'(reg_wdata);

  ////////////////////////////////////////////////////////////////////////////////
  // debug control register

  fdo_pkg::fdo_ctrl_t ctrl_r;
  fdo_pkg::fdo_ctrl_t ctrl_nxt;

  // reserved bits never stored, trigger and commit never held
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = wr_word;
    end
    ctrl_nxt.reserved = '0;
    ctrl_nxt.param_measure_trigger = 1'b0;
    ctrl_nxt.commit_measured_to_shadow = 1'b0;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= fdo_pkg::fdo_ctrl_t'(fdo_pkg::DEBUG_LOOP_OVERRIDE_CTRL_RST);
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // voltage override path

  wire logic vd_ok;
  wire logic vq_ok;
  fdo_pkg::fdo_vref_t vref_nxt;
  fdo_pkg::fdo_vref_t vref_r;

  assign vd_ok = code_valid(ctrl_nxt.direct_axis_voltage_override);
  assign vq_ok = code_valid(ctrl_nxt.quadrature_axis_voltage_override);

  // references are zero whenever the loops run normally
  always_comb begin
    vref_nxt = '0;
    vref_nxt.inner_loop_bypass = ctrl_nxt.inner_loop_bypass;
    if (ctrl_nxt.inner_loop_bypass) begin
      vref_nxt.vd_ref = code_to_ref(ctrl_nxt.direct_axis_voltage_override);
      vref_nxt.vq_ref = code_to_ref(ctrl_nxt.quadrature_axis_voltage_override);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      vref_r <= '0;
    end else begin
      vref_r <= vref_nxt;
    end
  end

  assign vref = vref_r;

  ////////////////////////////////////////////////////////////////////////////////
  // measurement trigger and shadow commit

  wire logic start_nxt;
  wire logic commit_nxt;
  logic start_r;
  logic commit_r;
  fdo_pkg::fdo_meas_sel_t sel_r;

  // a trigger while the routine already runs is dropped
  assign start_nxt = wr_ctrl && wr_word.param_measure_trigger && !meas_busy;
  assign commit_nxt = wr_ctrl && wr_word.commit_measured_to_shadow;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      start_r <= 1'b0;
      commit_r <= 1'b0;
      sel_r <= '0;
    end else begin
      start_r <= start_nxt;
      commit_r <= commit_nxt;
      sel_r <= ctrl_nxt.meas_sel;
    end
  end

  assign meas_start = start_r;
  assign shadow_commit = commit_r;
  assign meas_sel = sel_r;

  ////////////////////////////////////////////////////////////////////////////////
  // gain readback

  fdo_pkg::fdo_gain_t gain_r;
  fdo_pkg::fdo_gain_t gain_nxt;

  always_comb begin
    gain_nxt = '0;
    gain_nxt.inner_loop_prop_gain = inner_loop_prop_gain;
    gain_nxt.inner_loop_int_gain = inner_loop_int_gain;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gain_r <= fdo_pkg::fdo_gain_t'(fdo_pkg::INNER_LOOP_GAIN_READBACK_RST);
    end else begin
      gain_r <= gain_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  fdo_pkg::fdo_status_t status;
  logic [fdo_pkg::DATA_W-1:0] rdata_nxt;
  logic [fdo_pkg::DATA_W-1:0] rdata_r;

  always_comb begin
    status = '0;
    status.inner_loop_bypass = ctrl_r.inner_loop_bypass;
    status.vd_code_invalid = !code_valid(ctrl_r.direct_axis_voltage_override);
    status.vq_code_invalid = !code_valid(ctrl_r.quadrature_axis_voltage_override);
    status.meas_busy = meas_busy;
  end

  // control word reads back as zero; unmapped addresses read zero
  always_comb begin
    rdata_nxt = fdo_pkg::RDATA_IDLE;
    if (reg_rd && sel_gain) begin
      rdata_nxt = gain_r;
    end else if (reg_rd && sel_status) begin
      rdata_nxt = status;
    end else if (reg_rd && sel_ctrl) begin
      rdata_nxt = fdo_pkg::RDATA_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= fdo_pkg::RDATA_IDLE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_ctrl_reads_zero: assert property (
    (reg_rd && sel_ctrl) |=> (reg_rdata == '0))
    else $error("control register did not read back as zero");

  a_bypass_follows_write: assert property (
    wr_ctrl |=> (vref.inner_loop_bypass == $past(reg_wdata[26])))
    else $error("bypass output does not follow written bit 26");

  a_vd_positive: assert property (
    (wr_ctrl && wr_word.inner_loop_bypass &&
     (wr_word.direct_axis_voltage_override <= fdo_pkg::CODE_POS_MAX))
    |=> (vref.vd_ref == $signed({1'b0, $past(reg_wdata[25:16])})))
    else $error("positive d reference wrong");

  a_vd_negative: assert property (
    (wr_ctrl && wr_word.inner_loop_bypass &&
     (wr_word.direct_axis_voltage_override >= fdo_pkg::CODE_NEG_BASE) &&
     (wr_word.direct_axis_voltage_override <= fdo_pkg::CODE_NEG_MAX))
    |=> ((vref.vd_ref + $signed({1'b0, $past(reg_wdata[25:16])})) == 11'sh200))
    else $error("negative d reference wrong");

  a_vq_positive: assert property (
    (wr_ctrl && wr_word.inner_loop_bypass &&
     (wr_word.quadrature_axis_voltage_override <= fdo_pkg::CODE_POS_MAX))
    |=> (vref.vq_ref == $signed({1'b0, $past(reg_wdata[15:6])})))
    else $error("positive q reference wrong");

  a_vq_negative: assert property (
    (wr_ctrl && wr_word.inner_loop_bypass &&
     (wr_word.quadrature_axis_voltage_override >= fdo_pkg::CODE_NEG_BASE) &&
     (wr_word.quadrature_axis_voltage_override <= fdo_pkg::CODE_NEG_MAX))
    |=> ((vref.vq_ref + $signed({1'b0, $past(reg_wdata[15:6])})) == 11'sh200))
    else $error("negative q reference wrong");

  a_refs_zero_unbypassed: assert property (
    !vref.inner_loop_bypass |-> (vref.vd_ref == '0) && (vref.vq_ref == '0))
    else $error("voltage reference nonzero with loops enabled");

  a_vd_invalid_zero: assert property (
    (wr_ctrl && wr_word.inner_loop_bypass && !vd_ok) |=> (vref.vd_ref == '0))
    else $error("invalid d code did not give a zero reference");

  a_vq_invalid_zero: assert property (
    (wr_ctrl && wr_word.inner_loop_bypass && !vq_ok) |=> (vref.vq_ref == '0))
    else $error("invalid q code did not give a zero reference");

  a_bypass_clear_zero: assert property (
    (wr_ctrl && !wr_word.inner_loop_bypass) |=> (vref == '0))
    else $error("references not cleared when the loops were enabled");

  // vref and meas_sel only move on a write to the control register
  a_vref_holds: assert property (
    !wr_ctrl |=> $stable(vref))
    else $error("voltage references changed without a control write");

  a_select_holds: assert property (
    !wr_ctrl |=> $stable(meas_sel))
    else $error("measurement selection changed without a control write");

  a_start_one_pulse: assert property (
    (wr_ctrl && reg_wdata[5] && !meas_busy) |=> meas_start)
    else $error("measurement start missing after a trigger");

  // back-to-back triggers may keep the start high, a lone one may not
  a_start_needs_trigger: assert property (
    meas_start |-> $past(wr_ctrl) && $past(reg_wdata[5]) && !$past(meas_busy))
    else $error("measurement start without an accepted trigger");

  a_trigger_busy_dropped: assert property (
    (wr_ctrl && wr_word.param_measure_trigger && meas_busy) |=> !meas_start)
    else $error("trigger accepted while the routine was running");

  a_select_captured: assert property (
    wr_ctrl |=> (meas_sel == $past(reg_wdata[4:1])))
    else $error("measurement selection does not match written bits");

  a_commit_pulse: assert property (
    shadow_commit |-> $past(wr_ctrl) && $past(reg_wdata[0]))
    else $error("shadow commit without a write of bit 0");

  a_commit_on_write: assert property (
    (wr_ctrl && wr_word.commit_measured_to_shadow) |=> shadow_commit)
    else $error("written commit bit gave no shadow commit");

  a_commit_no_start: assert property (
    (wr_ctrl && !wr_word.param_measure_trigger) |=> !meas_start)
    else $error("measurement start without the trigger bit");

  a_gain_readback: assert property (
    (reg_rd && sel_gain) |=> (reg_rdata[31:22] == $past(inner_loop_prop_gain, 2)) &&
                             (reg_rdata[21:12] == $past(inner_loop_int_gain, 2)) &&
                             (reg_rdata[11:0] == '0))
    else $error("gain readback wrong");

  a_reserved_dropped: assert property (
    wr_ctrl |=> (ctrl_r.reserved == '0))
    else $error("reserved control bits were stored");

  // read data stands one cycle and is zero otherwise
  a_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data not zero outside a read answer");

  a_unmapped_reads_zero: assert property (
    (reg_rd && !sel_gain && !sel_status) |=> (reg_rdata == '0))
    else $error("write-only or unmapped address read back nonzero");

  a_status_readback: assert property (
    (reg_rd && !reg_wr && sel_status) |=> (reg_rdata[0] == vref.inner_loop_bypass) &&
                                          (reg_rdata[3] == $past(meas_busy)) &&
                                          (reg_rdata[31:4] == '0))
    else $error("status word wrong");

  a_unmapped_write_ignored: assert property (
    (reg_wr && !sel_ctrl) |=> $stable(vref) && $stable(meas_sel) &&
                              !meas_start && !shadow_commit)
    else $error("write to another address changed the outputs");

endmodule : fdo_debug_override_ctrl

`default_nettype wire

//--- src/fdo_pkg.sv
// shared constants and types for the debug loop override control block
`default_nettype none

package fdo_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CODE_W = 10;
  localparam int REF_W = 11;

  // register offsets
  localparam logic [ADDR_W-1:0] DEBUG_LOOP_OVERRIDE_CTRL_OFS = 12'h0ee;
  localparam logic [ADDR_W-1:0] INNER_LOOP_GAIN_READBACK_OFS = 12'h0f0;
  localparam logic [ADDR_W-1:0] OVERRIDE_STATUS_OFS = 12'h0f8;

  // reset values
  localparam logic [DATA_W-1:0] DEBUG_LOOP_OVERRIDE_CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] INNER_LOOP_GAIN_READBACK_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

  // override code decoding: value = code / 500 from 0 to 500, -(code - 512) / 500 from 512 to 1000
  localparam logic [CODE_W-1:0] CODE_POS_MAX = 10'h1f4;
  localparam logic [CODE_W-1:0] CODE_NEG_BASE = 10'h200;
  localparam logic [CODE_W-1:0] CODE_NEG_MAX = 10'h3e8;

  // measurement selection, bits 4 down to 1 of the control word
  typedef struct packed {
    logic measure_winding_resistance;
    logic measure_winding_inductance;
    logic measure_back_emf_constant;
    logic measure_mechanical_params;
  } fdo_meas_sel_t;

  // control word layout: 31-27 reserved, 26 bypass, 25-16 d, 15-6 q, 5 trigger, 4-1 select, 0 commit
  typedef struct packed {
    logic [4:0] reserved;
    logic inner_loop_bypass;
    logic [CODE_W-1:0] direct_axis_voltage_override;
    logic [CODE_W-1:0] quadrature_axis_voltage_override;
    logic param_measure_trigger;
    fdo_meas_sel_t meas_sel;
    logic commit_measured_to_shadow;
  } fdo_ctrl_t;

  // gain readback layout: 31-22 proportional, 21-12 integral, 11-0 reserved
  typedef struct packed {
    logic [CODE_W-1:0] inner_loop_prop_gain;
    logic [CODE_W-1:0] inner_loop_int_gain;
    logic [11:0] reserved;
  } fdo_gain_t;

  // voltage references handed to the inner loop, in units of 1/500 of full scale
  typedef struct packed {
    logic inner_loop_bypass;
    logic signed [REF_W-1:0] vd_ref;
    logic signed [REF_W-1:0] vq_ref;
  } fdo_vref_t;

  // own status word: 3 measurement busy, 2 q code invalid, 1 d code invalid, 0 bypass
  typedef struct packed {
    logic [27:0] reserved;
    logic meas_busy;
    logic vq_code_invalid;
    logic vd_code_invalid;
    logic inner_loop_bypass;
  } fdo_status_t;

endpackage : fdo_pkg

`default_nettype wire
